// ---- pkg/cps_pkg.sv ----
// Constants, state codes and carrier types of the cellular power sequencer.
// Assumes one 100 MHz clock and a synchronous active-low reset.
// Operation
// [RQ1] Held-low power request switches the subsystem on
// [RQ2] Reached alarm switches the subsystem on
// [RQ3] Weak pull-ups on request and reset inputs
// [RQ4] Other party only pulls request/reset lines low
// [RQ5] Pins high impedance until interface supply on
// [RQ6] Core reset held, then pins configured in order
// [RQ7] Ready after configuration; optional greeting message
// [RQ8] Other party drives no pins before supply
// [RQ9] Host sends no commands before ready
// [RQ10] Power-off command or pulse: save, detach, off
// [RQ11] Power-off command answered with OK response
// [RQ12] Switch-off end: pins tri-stated, regulators off
// [RQ13] Stay off until a switch-on event
// [RQ14] Other party keeps supply until interface supply off
// [RQ15] Supply loss: abrupt shutdown, no save or detach
// [RQ16] Enabled temperature supervision forces abrupt shutdown
// [RQ17] Switch-off end shown by supply or break
// [RQ18] Function level 16: graceful save, detach, reboot
// [RQ19] Held-low reset input: abrupt reboot, no save
// [RQ20] Host uses reset input only as fallback
// [RQ21] Separate cycle thresholds for on, off, reset
// [RQ22] Interface supply follows switched-on state
`default_nettype none

package cps_pkg;

    // ************************************************************
    // Widths and defaults
    // ************************************************************
    localparam int          CPS_CNT_W        = 16;
    localparam int          CPS_NUM_PINS     = 4;
    localparam int          CPS_CMD_W        = 8;
    localparam int          CPS_ON_LOW_CYC   = 100;
    localparam int          CPS_OFF_LOW_CYC  = 200;
    localparam int          CPS_RST_LOW_CYC  = 300;
    localparam int          CPS_CORE_RST_CYC = 50;
    localparam int          CPS_PIN_STEP_CYC = 8;
    localparam int          CPS_BREAK_CYC    = 16;
    // Function level value that asks for a graceful reboot
    localparam logic [7:0]  CPS_FUNC_REBOOT  = 8'h10;
    localparam logic        CPS_PIN_IDLE     = 1'b1;

    // ************************************************************
    // State codes, one-hot
    // ************************************************************
    typedef enum logic [5:0] {
        CPS_ST_OFF    = 6'h01,
        CPS_ST_BOOT   = 6'h02,
        CPS_ST_PINCFG = 6'h04,
        CPS_ST_RUN    = 6'h08,
        CPS_ST_SHUT   = 6'h10,
        CPS_ST_BREAK  = 6'h20
    } cps_state_type;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic                 power_off;
        logic                 func_level;
        logic [CPS_CMD_W-1:0] func_value;
    } cps_cmd_type;

    typedef struct packed {
        logic save_req;
        logic detach_req;
        logic ok_resp;
        logic greeting;
    } cps_fw_type;

endpackage

`default_nettype wire

// ---- rtl/cps_low_qualifier.sv ----
// Low-level qualifier for an active-low, pulled-up input pin.
// Assumes the pin is asynchronous to clock_in; two flops catch it first.
`default_nettype none

module cps_low_qualifier #(
    parameter int CNT_W = cps_pkg::CPS_CNT_W
) (
    input  wire logic             clock_in,
    input  wire logic             resetn_in,
    input  wire logic             pin_n_in,
    output logic                  low_level_out,
    output logic [CNT_W-1:0]      low_cnt_out,
    output logic                  rise_out
);
    import cps_pkg::*;

    logic             meta_ff;
    logic             sync_ff;
    logic             prev_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    wire              cnt_full = &cnt_ff;

    // ************************************************************
    // Synchroniser, idle level matches the pull-up
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            meta_ff <= CPS_PIN_IDLE;
            sync_ff <= CPS_PIN_IDLE;
            prev_ff <= CPS_PIN_IDLE;
        end else begin
            meta_ff <= pin_n_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Saturating low-time counter; it still advances in the release cycle and clears after it
    assign nxt_cnt = !prev_ff ? (cnt_full ? cnt_ff : cnt_ff + 1'b1) : '0; // RQ21

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign low_level_out = !sync_ff;
    assign low_cnt_out   = cnt_ff;
    assign rise_out      = sync_ff && !prev_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    cnt_clear_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ21
        prev_ff |=> (cnt_ff == '0))
        else $error("low counter not cleared after high level");
    cnt_step_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ21
        (!prev_ff && !cnt_full) |=> (cnt_ff == $past(cnt_ff) + 1'b1))
        else $error("low counter did not advance");

endmodule

`default_nettype wire

// ---- rtl/cps_sequencer.sv ----
// Power-state sequencer of the cellular subsystem.
// Assumes firmware handshakes share clock_in; supply and temperature
// flags and the two pins come from outside and are synchronised here.
`default_nettype none

module cps_sequencer #(
    parameter int CNT_W        = cps_pkg::CPS_CNT_W,
    parameter int NUM_PINS     = cps_pkg::CPS_NUM_PINS,
    parameter int ON_LOW_CYC   = cps_pkg::CPS_ON_LOW_CYC,
    parameter int OFF_LOW_CYC  = cps_pkg::CPS_OFF_LOW_CYC,
    parameter int RST_LOW_CYC  = cps_pkg::CPS_RST_LOW_CYC,
    parameter int CORE_RST_CYC = cps_pkg::CPS_CORE_RST_CYC,
    parameter int PIN_STEP_CYC = cps_pkg::CPS_PIN_STEP_CYC,
    parameter int BREAK_CYC    = cps_pkg::CPS_BREAK_CYC
) (
    input  wire logic                 clock_in,
    input  wire logic                 resetn_in,
    input  wire logic                 power_request_n_in,
    input  wire logic                 ext_reset_n_in,
    input  wire logic                 supply_ok_in,
    input  wire logic                 temp_danger_in,
    input  wire logic                 temp_supervisor_en_in,
    input  wire logic                 greeting_en_in,
    input  wire logic                 rtc_alarm_in,
    input  wire cps_pkg::cps_cmd_type cmd_in,
    input  wire logic                 settings_saved_in,
    input  wire logic                 detach_done_in,
    output logic                      power_request_pullup_out,
    output logic                      ext_reset_pullup_out,
    output logic                      vint_en_out,
    output logic                      regulators_en_out,
    output logic                      core_reset_n_out,
    output logic [NUM_PINS-1:0]       pin_oe_out,
    output logic                      serial_break_out,
    output logic                      ready_out,
    output cps_pkg::cps_fw_type       fw_out
);
    import cps_pkg::*;

    cps_state_type        state_ff;
    cps_state_type        nxt_state;
    logic [CNT_W-1:0]     timer_ff;
    logic [NUM_PINS-1:0]  pin_cfg_ff;
    logic                 sup_meta_ff;
    logic                 sup_ff;
    logic                 tmp_meta_ff;
    logic                 tmp_ff;
    logic                 pullup_ff;
    logic                 reboot_ff;
    logic                 pwr_arm_ff;
    logic                 saved_ff;
    logic                 detached_ff;
    cps_fw_type           fw_ff;
    logic                 pwr_low;
    logic [CNT_W-1:0]     pwr_cnt;
    logic                 pwr_rise;
    logic [CNT_W-1:0]     rst_cnt;

    // Compare a counter against a cycle figure, both at counter width
    function automatic logic cnt_is(input logic [CNT_W-1:0] cnt, input int figure);
        cnt_is = (cnt == CNT_W'(figure));
    endfunction

    // ************************************************************
    // Pin qualifiers
    // ************************************************************
    cps_low_qualifier #(.CNT_W(CNT_W)) u_pwr_qual (
        .clock_in      (clock_in),
        .resetn_in     (resetn_in),
        .pin_n_in      (power_request_n_in),
        .low_level_out (pwr_low),
        .low_cnt_out   (pwr_cnt),
        .rise_out      (pwr_rise)
    );

    cps_low_qualifier #(.CNT_W(CNT_W)) u_rst_qual (
        .clock_in      (clock_in),
        .resetn_in     (resetn_in),
        .pin_n_in      (ext_reset_n_in),
        .low_level_out (),
        .low_cnt_out   (rst_cnt),
        .rise_out      ()
    );

    // Analog flags arrive asynchronously; two flops before any use
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            sup_meta_ff <= 1'b0;
            sup_ff      <= 1'b0;
            tmp_meta_ff <= 1'b0;
            tmp_ff      <= 1'b0;
        end else begin
            sup_meta_ff <= supply_ok_in;
            sup_ff      <= sup_meta_ff;
            tmp_meta_ff <= temp_danger_in;
            tmp_ff      <= tmp_meta_ff;
        end
    end

    // ************************************************************
    // Event decode
    // ************************************************************
    wire st_off   = state_ff == CPS_ST_OFF;
    wire st_boot  = state_ff == CPS_ST_BOOT;
    wire st_cfg   = state_ff == CPS_ST_PINCFG;
    wire st_run   = state_ff == CPS_ST_RUN;
    wire st_shut  = state_ff == CPS_ST_SHUT;
    wire st_break = state_ff == CPS_ST_BREAK;
    // Equality fires once per press; counter saturation keeps it from repeating
    wire power_request_n_hit = st_off && sup_ff && cnt_is(pwr_cnt, ON_LOW_CYC);            // RQ1
    wire alarm_hit  = st_off && sup_ff && rtc_alarm_in;                           // RQ2
    // Armed only by a high level seen while running, so the switch-on press
    // still held after boot cannot count as a switch-off pulse
    wire pulse_off  = st_run && pwr_arm_ff && pwr_rise
                      && (pwr_cnt >= CNT_W'(OFF_LOW_CYC));                         // RQ10
    wire cmd_off    = st_run && cmd_in.power_off;                                 // RQ10
    wire cmd_reboot = st_run && !cmd_in.power_off && cmd_in.func_level
                      && (cmd_in.func_value == CPS_FUNC_REBOOT);                  // RQ18
    wire xrst_hit   = !st_off && cnt_is(rst_cnt, RST_LOW_CYC);                    // RQ19
    wire abort      = !st_off && (!sup_ff || (temp_supervisor_en_in && tmp_ff)); // RQ15 RQ16
    wire boot_done  = st_boot && cnt_is(timer_ff, CORE_RST_CYC - 1);
    wire pin_step   = st_cfg && cnt_is(timer_ff, PIN_STEP_CYC - 1);
    wire cfg_done   = st_cfg && (&pin_cfg_ff);
    wire shut_done  = st_shut && saved_ff && detached_ff;
    wire break_done = st_break && cnt_is(timer_ff, BREAK_CYC - 1);

    // ************************************************************
    // Next state; abrupt events outrank every graceful step
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CPS_ST_OFF: begin
                if (power_request_n_hit || alarm_hit) begin
                    nxt_state = CPS_ST_BOOT;                                      // RQ1 RQ2
                end
            end
            CPS_ST_BOOT: begin
                if (boot_done) begin
                    nxt_state = CPS_ST_PINCFG;                                    // RQ6
                end
            end
            CPS_ST_PINCFG: begin
                if (cfg_done) begin
                    nxt_state = CPS_ST_RUN;                                       // RQ7
                end
            end
            CPS_ST_RUN: begin
                if (cmd_off || pulse_off || cmd_reboot) begin
                    nxt_state = CPS_ST_SHUT;                                      // RQ10 RQ18
                end
            end
            CPS_ST_SHUT: begin
                if (shut_done) begin
                    nxt_state = CPS_ST_BREAK;
                end
            end
            CPS_ST_BREAK: begin
                if (break_done) begin
                    nxt_state = reboot_ff ? CPS_ST_BOOT : CPS_ST_OFF;             // RQ12 RQ13
                end
            end
            default: begin
                nxt_state = CPS_ST_OFF;
            end
        endcase
        if (xrst_hit) begin
            nxt_state = CPS_ST_BOOT;                                              // RQ19
        end
        if (abort) begin
            nxt_state = CPS_ST_OFF;                                               // RQ15 RQ16
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state_ff <= CPS_ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Phase timer restarts on every state change and on each pin step
    always_ff @(posedge clock_in) begin
        if (!resetn_in || nxt_state != state_ff || pin_step) begin
            timer_ff <= '0;
        end else begin
            timer_ff <= timer_ff + 1'b1;
        end
    end

    // ************************************************************
    // Pin release, one pin per step in fixed low-to-high order
    // ************************************************************
    wire pins_live = (nxt_state == CPS_ST_PINCFG) || (nxt_state == CPS_ST_RUN)
                     || (nxt_state == CPS_ST_SHUT);

    always_ff @(posedge clock_in) begin
        if (!resetn_in || !pins_live) begin
            pin_cfg_ff <= '0;                                                     // RQ5 RQ12
        end else if (pin_step) begin
            pin_cfg_ff <= {pin_cfg_ff[NUM_PINS-2:0], 1'b1};                       // RQ6
        end
    end

    // ************************************************************
    // Switch-off bookkeeping
    // ************************************************************
    // A done strobe outside the shut state is dropped: the clear outranks the set
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            saved_ff    <= 1'b0;
            detached_ff <= 1'b0;
            reboot_ff   <= 1'b0;
            pwr_arm_ff  <= 1'b0;
            pullup_ff   <= 1'b1;                                                  // RQ3
        end else begin
            saved_ff    <= st_shut && (saved_ff || settings_saved_in);
            detached_ff <= st_shut && (detached_ff || detach_done_in);
            pwr_arm_ff  <= st_run && (pwr_arm_ff || !pwr_low);
            pullup_ff   <= 1'b1;                                                  // RQ3
            if (st_run && nxt_state == CPS_ST_SHUT) begin
                reboot_ff <= cmd_reboot;                                          // RQ18
            end
        end
    end

    // Firmware requests and one-cycle answers
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            fw_ff <= '0;
        end else begin
            fw_ff.save_req   <= (nxt_state == CPS_ST_SHUT) && !saved_ff && !st_run
                                || (st_run && nxt_state == CPS_ST_SHUT);          // RQ10
            fw_ff.detach_req <= (nxt_state == CPS_ST_SHUT) && !detached_ff && !st_run
                                || (st_run && nxt_state == CPS_ST_SHUT);          // RQ10
            fw_ff.ok_resp    <= cmd_off && !abort && !xrst_hit;                   // RQ11
            fw_ff.greeting   <= cfg_done && greeting_en_in && !abort && !xrst_hit; // RQ7
        end
    end

    // ************************************************************
    // Outputs decoded from the state register, plus the pin, pull-up and firmware flops
    // ************************************************************
    assign vint_en_out              = !st_off;                                    // RQ22
    assign regulators_en_out        = !st_off;                                    // RQ12
    assign core_reset_n_out         = st_cfg || st_run || st_shut || st_break;    // RQ6
    assign pin_oe_out               = pin_cfg_ff;
    assign serial_break_out         = st_break;                                   // RQ17
    assign ready_out                = st_run;                                     // RQ7
    assign power_request_pullup_out = pullup_ff;
    assign ext_reset_pullup_out     = pullup_ff;
    assign fw_out                   = fw_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cps_cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    sequence shut_entry_s;
        st_run && (cmd_off || pulse_off) && !abort && !xrst_hit;
    endsequence
    sequence shut_running_s;
        st_shut && fw_ff.save_req && fw_ff.detach_req;
    endsequence

    press_boot_a: assert property (power_request_n_hit && !abort |=> st_boot) // RQ1
        else $error("held power request did not start boot");
    alarm_boot_a: assert property (alarm_hit && !abort |=> st_boot) // RQ2
        else $error("alarm did not start boot");
    pullups_on_a: assert property (power_request_pullup_out && ext_reset_pullup_out) // RQ3
        else $error("input pull-up dropped");
    pins_hiz_a: assert property (!vint_en_out |-> pin_oe_out == '0) // RQ5
        else $error("pin driven without interface supply");
    core_hold_a: assert property (st_boot |-> !core_reset_n_out && pin_oe_out == '0) // RQ6
        else $error("core or pins active during boot reset");
    ready_cfg_a: assert property (ready_out |-> (&pin_oe_out)) // RQ7
        else $error("ready before all pins configured");
    graceful_off_a: assert property (shut_entry_s |=> shut_running_s) // RQ10
        else $error("switch-off did not request save and detach");
    ok_answer_a: assert property (cmd_off && !abort && !xrst_hit |=> fw_ff.ok_resp) // RQ11
        else $error("power-off command not answered");
    end_off_a: assert property (break_done && !reboot_ff && !abort && !xrst_hit
        |=> !vint_en_out && !regulators_en_out && pin_oe_out == '0) // RQ12
        else $error("switch-off end left supply or pins on");
    stay_off_a: assert property (st_off && !power_request_n_hit && !alarm_hit |=> st_off) // RQ13
        else $error("left off state without an event");
    supply_drop_a: assert property (!st_off && !sup_ff |=> st_off && !fw_ff.save_req) // RQ15
        else $error("supply loss did not shut down abruptly");
    temp_drop_a: assert property (!st_off && temp_supervisor_en_in && tmp_ff |=> st_off) // RQ16
        else $error("temperature danger did not shut down");
    end_seen_a: assert property (st_shut ##1 st_off |-> !$past(sup_ff) ||
        $past(temp_supervisor_en_in && tmp_ff)) // RQ17
        else $error("graceful switch-off ended without break phase");
    reboot16_a: assert property (cmd_reboot && !abort && !xrst_hit
        |=> st_shut && reboot_ff) // RQ18
        else $error("function level reboot not started gracefully");
    ext_reset_a: assert property (xrst_hit && !abort |=> st_boot && !fw_ff.save_req) // RQ19
        else $error("reset input did not reboot abruptly");
    vint_track_a: assert property (vint_en_out == !st_off) // RQ22
        else $error("interface supply does not follow state");

endmodule

`default_nettype wire

// ---- bench/cps_host_model.sv ----
// Host model: pulls the request and reset pins low, answers firmware steps.
// Assumes it shares clock_in with the sequencer; the bench says when to press.
`default_nettype none

module cps_host_model (
    input  wire logic                 clock_in,
    input  wire logic                 press_in,
    input  wire logic                 rst_press_in,
    input  wire logic                 pwr_pullup_in,
    input  wire logic                 rst_pullup_in,
    input  wire logic [3:0]           ack_dly_in,
    input  wire cps_pkg::cps_fw_type  fw_in,
    output logic                      pwr_n_out,
    output logic                      rst_n_out,
    output logic                      saved_out,
    output logic                      detached_out
);
    import cps_pkg::*;
    logic [4:0] wait_ff;
    // Open drain only: high comes from the pull-up, never from the host;
    // no general pin is driven from this side at all
    assign pwr_n_out = press_in ? 1'b0 : pwr_pullup_in;
    assign rst_n_out = rst_press_in ? 1'b0 : rst_pullup_in;
    // Slow or prompt firmware, detach lands a cycle after the save
    assign saved_out = fw_in.save_req && (wait_ff == {1'b0, ack_dly_in});
    assign detached_out = fw_in.detach_req && (wait_ff == {1'b0, ack_dly_in} + 5'h01);
    // Count cycles since the save request was raised
    always_ff @(posedge clock_in) begin
        wait_ff <= fw_in.save_req ? wait_ff + 5'h01 : 5'h00;
    end
endmodule

`default_nettype wire

// ---- bench/test_cellular_power_sequencer.sv ----
// Self-checking bench of the power sequencer with a host model on its pins.
// Assumes short thresholds; supply and commands come from the bench itself.
`default_nettype none

module test_cellular_power_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import cps_pkg::*;
    // ************************************************************
    // Stimulus, model and checks
    // ************************************************************
    logic clock_in = 1'b0, resetn_in, press, rst_press, supply, temp, temp_en, greet_en;
    logic alarm, pwr_n, rst_n, saved, detached, pwr_pu, rst_pu, vint, regs, core_n;
    logic brk, ready;
    logic [3:0] oe, ack_dly;
    cps_cmd_type cmd;
    cps_fw_type fw;
    int n_fail = 0, compares = 0, cyc = 0, seed, k;
    always #5 clock_in = ~clock_in;
    cps_sequencer #(.ON_LOW_CYC(4), .OFF_LOW_CYC(6), .RST_LOW_CYC(8), .CORE_RST_CYC(3),
        .PIN_STEP_CYC(2), .BREAK_CYC(3)) cps_sequencer_i (.clock_in(clock_in),
        .resetn_in(resetn_in), .power_request_n_in(pwr_n), .ext_reset_n_in(rst_n),
        .supply_ok_in(supply), .temp_danger_in(temp), .temp_supervisor_en_in(temp_en),
        .greeting_en_in(greet_en), .rtc_alarm_in(alarm), .cmd_in(cmd),
        .settings_saved_in(saved), .detach_done_in(detached),
        .power_request_pullup_out(pwr_pu), .ext_reset_pullup_out(rst_pu),
        .vint_en_out(vint), .regulators_en_out(regs), .core_reset_n_out(core_n),
        .pin_oe_out(oe), .serial_break_out(brk), .ready_out(ready), .fw_out(fw));
    cps_host_model cps_host_model_i (.clock_in(clock_in), .press_in(press),
        .rst_press_in(rst_press), .pwr_pullup_in(pwr_pu), .rst_pullup_in(rst_pu),
        .ack_dly_in(ack_dly), .fw_in(fw), .pwr_n_out(pwr_n), .rst_n_out(rst_n),
        .saved_out(saved), .detached_out(detached));
    // All pins configured once the order has run through
    function automatic logic [31:0] all_pins();
        return (32'h1 << CPS_NUM_PINS) - 32'h1;
    endfunction
    function automatic logic pick(int s);
        case (s)
            0: return ready;
            1: return vint;
            2: return brk;
            3: return fw.save_req;
            default: return core_n;
        endcase
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(int n = 1);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    // Bounded wait, so a stuck sequence shows as a mismatch, not a hang
    task automatic wait_sig(int s, logic v, int lim);
        int i;
        for (i = 0; i < lim && pick(s) !== v; i++) tick();
        check("wait", pick(s), v);
    endtask
    task automatic power_on();
        press <= 1'b1;
        wait_sig(1, 1'b1, 20);
        check("core_rst", core_n, 1'b0);
        check("oe_boot", oe, 32'h0);
        press <= 1'b0;
        wait_sig(0, 1'b1, 60);
        check("greet", fw.greeting, greet_en);
        check("oe_run", oe, all_pins());
        check("regs", regs, 1'b1);
    endtask
    // An idle cycle first, so two commands in a row never merge into one
    task automatic command(logic [9:0] c);
        tick();
        cmd <= c;
        tick();
        cmd <= '0;
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        seed = 32'hb45a;
        {press, rst_press, temp, temp_en, alarm, resetn_in} <= '0;
        {supply, greet_en} <= 2'b11;
        cmd <= '0;
        ack_dly <= 4'h0;
        tick(6);
        resetn_in <= 1'b1;
        tick(3);
        check("pullups", {pwr_pu, rst_pu}, 2'b11);
        check("oe_off", oe, 32'h0);
        press <= 1'b1;
        tick(3);
        press <= 1'b0;
        tick(10);
        check("short", vint, 1'b0);
        power_on();
        command({2'b10, 8'h00});
        check("ok", fw.ok_resp, 1'b1);
        check("save", fw.save_req & fw.detach_req, 1'b1);
        wait_sig(2, 1'b1, 30);
        check("vint_brk", vint, 1'b1);
        wait_sig(1, 1'b0, 10);
        check("oe_end", oe, 32'h0);
        check("regs_off", regs, 1'b0);
        // Commands and temperature noise of any kind leave an idle subsystem off
        for (k = 0; k < 30; k++) begin
            {temp, temp_en} <= 2'($random(seed));
            command(10'($random(seed)));
            check("stay_off", vint, 1'b0);
        end
        greet_en <= 1'($random(seed));
        {temp, temp_en} <= 2'b00;
        alarm <= 1'b1;
        tick();
        alarm <= 1'b0;
        wait_sig(0, 1'b1, 60);
        check("greet2", fw.greeting, greet_en);
        for (k = 0; k < 8; k++) begin
            command({2'b01, 8'($random(seed)) | 8'h20});
            check("ign_func", ready, 1'b1);
        end
        ack_dly <= 4'($random(seed));
        command({2'b01, CPS_FUNC_REBOOT});
        check("rb_save", fw.save_req, 1'b1);
        wait_sig(4, 1'b0, 40);
        check("rb_vint", vint, 1'b1);
        wait_sig(0, 1'b1, 60);
        press <= 1'b1;
        tick(9);
        press <= 1'b0;
        wait_sig(3, 1'b1, 10);
        wait_sig(1, 1'b0, 40);
        power_on();
        rst_press <= 1'b1;
        wait_sig(4, 1'b0, 20);
        check("rst_save", fw.save_req, 1'b0);
        check("rst_vint", vint, 1'b1);
        rst_press <= 1'b0;
        wait_sig(0, 1'b1, 60);
        supply <= 1'b0;
        wait_sig(1, 1'b0, 6);
        check("abrupt", fw.save_req, 1'b0);
        supply <= 1'b1;
        tick(3);
        power_on();
        temp <= 1'b1;
        tick(10);
        check("temp_off", vint, 1'b1);
        temp_en <= 1'b1;
        wait_sig(1, 1'b0, 6);
        print_verdict();
    end
endmodule

`default_nettype wire
